// ===== hdl/sbh_host_port.sv
// Host port, board select and local bus access of a slave processor board
//
// Functional notes
// RQ1 - Decode select port at even and control port at odd address of a pair
// RQ2 - Boards sharing a port pair need distinct select codes, sixteen at most
// RQ3 - Eight port sets chosen by one switch and two jumpers
// RQ4 - Board clock halved to form the processor clock output
// RQ5 - Grant acknowledge re-timed on the inverted processor clock
// RQ6 - Refresh scan steps one word address about every 16 microseconds
// RQ7 - Row strobe on every non-I/O local cycle, whatever the address
// RQ8 - Local memory cycles run with no wait states
// RQ9 - UART chip select covers 32 local I/O ports at a programmable base
// RQ10 - UART on even lane only, register number doubled in I/O space
// RQ11 - Read buffers face host only with input strobe, wait done, status
// RQ12 - Write buffers face local bus with write strobe, grant, status
// RQ13 - Full 16-bit word moved whenever the host requests one
// RQ14 - Crossover for odd byte writes and even byte reads
// RQ15 - Host address driven locally only while grant acknowledge is low
// RQ16 - Select port writes decoded even when the board is not enabled
// RQ17 - Window hits and control writes only while the board is enabled
// RQ18 - Enabled stays set until bus reset or a non-matching select write
// RQ19 - Local processor held reset from power-up until host releases it
// RQ20 - Host can force local processor reset at any time the board is enabled
// RQ21 - 64 Kbyte window placed on any 32 Kbyte boundary of board memory
// RQ22 - Board is slave only and never requests bus mastership
// RQ23 - Host writes the select code in the low nibble of the select byte
// RQ24 - Window hit when A16 to A23 match the switch and board is enabled
// RQ25 - Host ready held in wait until local grant acknowledge
// RQ26 - Enabled captured at trailing write strobe, cleared by bus reset
`timescale 1ns/10ps
module sbh_host_port
    import sbh_pkg::*;
#(
    parameter int REFRESH_CNT = REFRESH_CYCLES
) (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    // Host bus
    input  wire logic [23:0] host_addr_i,
    input  wire logic [7:0]  host_do_i,
    input  wire logic [7:0]  host_di_i,
    input  wire logic        s_memr_i,
    input  wire logic        s_out_i,
    input  wire logic        s_inp_i,
    input  wire logic        s_wo_n_i,
    input  wire logic        p_dbin_i,
    input  wire logic        p_wr_n_i,
    input  wire logic        p_sync_i,
    input  wire logic        sxtrq_n_i,
    output logic      [7:0]  host_di_o,
    output logic      [7:0]  host_do_o,
    output logic             host_do_oe_o,
    output logic             host_di_oe_o,
    output logic             sixtn_n_o,
    output logic             host_ready_o,
    // Straps
    input  wire logic [3:0]  select_code_switch_i,
    input  wire logic [7:0]  window_page_switch_i,
    input  wire logic        port_set_switch_i,
    input  wire logic        port_jumper_low_i,
    input  wire logic        port_jumper_high_i,
    // Local bus
    input  wire logic        local_grant_ack_n_i,
    input  wire logic        local_cycle_i,
    input  wire logic        local_io_i,
    input  wire logic [15:0] local_io_addr_i,
    input  wire logic [15:0] local_pcs_base_i,
    input  wire logic [15:0] local_data_i,
    output logic             cpu_clock_output_o,
    output logic             local_hold_req_o,
    output logic             synced_grant_ack_n_o,
    output logic [18:0]      local_address_bus_o,
    output logic             local_addr_oe_o,
    output logic [15:0]      local_data_o,
    output logic [1:0]       local_byte_en_o,
    output logic             data_out_buffer_enable_n_o,
    output logic             data_in_buffer_enable_n_o,
    output logic             byte_cross_o,
    output logic             wait_finished_o,
    output logic             board_enabled_n_o,
    output logic             window_hit_n_o,
    output logic             local_cpu_reset_n_o,
    output logic             local_int_set_o,
    output logic             host_int_enable_o,
    output logic             row_strobe_n_o,
    output logic             local_ready_o,
    output logic             peripheral_select_zero_n_o,
    output logic [3:0]       uart_reg_o,
    output logic             refresh_req_o,
    output logic [17:0]      refresh_addr_o
);

    // Port address of a pair from the strap index, odd selects control
    function automatic logic [15:0] port_addr(input logic [2:0] idx,
                                              input logic       odd);
        port_addr = (odd ? CTRL_PORT_BASE : SEL_PORT_BASE)
                  + PORT_PAIR_STEP * {13'h0000, idx};
    endfunction : port_addr

    // Board address of a host window offset; page bits arrive inverted
    function automatic logic [18:0] dram_addr(input logic [3:0]  page_n,
                                              input logic [15:0] offs);
        dram_addr = {~page_n, 15'h0000} + {3'h0, offs};
    endfunction : dram_addr

    logic        rst_meta_q;
    logic        rst_q;
    logic [23:0] addr_s;
    logic [7:0]  do_s;
    logic [7:0]  di_s;
    logic        memr_s;
    logic        out_s;
    logic        inp_s;
    logic        wo_n_s;
    logic        dbin_s;
    logic        wr_n_s;
    logic        sync_s;
    logic        xtrq_n_s;
    logic [3:0]  sel_sw_s;
    logic [7:0]  win_sw_s;
    logic        pset_s;
    logic        jlow_s;
    logic        jhigh_s;
    logic        grant_n_s;
    logic        lcyc_s;
    logic        lio_s;
    logic [15:0] lio_addr_s;
    logic [15:0] pcs_base_s;
    logic [15:0] ldata_s;

    // Reset released through two flip-flops
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta_q <= 1'b0;
            rst_q      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_q      <= rst_meta_q;
        end
    end

    sbh_pin_sync #(.W(48), .INIT(48'h0000_0000_0015)) u_host_sync (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_q),
        .pin_i     ({host_addr_i, host_do_i, host_di_i, s_memr_i, s_out_i,
                     s_inp_i, s_wo_n_i, p_dbin_i, p_wr_n_i, p_sync_i,
                     sxtrq_n_i}),
        .level_o   ({addr_s, do_s, di_s, memr_s, out_s, inp_s, wo_n_s,
                     dbin_s, wr_n_s, sync_s, xtrq_n_s})
    );

    sbh_pin_sync #(.W(15), .INIT(15'h0000)) u_strap_sync (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_q),
        .pin_i     ({select_code_switch_i, window_page_switch_i,
                     port_set_switch_i, port_jumper_low_i,
                     port_jumper_high_i}),
        .level_o   ({sel_sw_s, win_sw_s, pset_s, jlow_s, jhigh_s})
    );

    sbh_pin_sync #(.W(51), .INIT(51'h4_0000_0000_0000)) u_local_sync (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_q),
        .pin_i     ({local_grant_ack_n_i, local_cycle_i, local_io_i,
                     local_io_addr_i, local_pcs_base_i, local_data_i}),
        .level_o   ({grant_n_s, lcyc_s, lio_s, lio_addr_s, pcs_base_s,
                     ldata_s})
    );

    sbh_state_type state_q;
    sbh_state_type state_d;
    logic [7:0]    ctrl_q;
    logic          enabled_q;
    logic          wr_n_prev_q;
    logic          cpu_clk_q;
    logic          sync_ack_n_q;
    logic [9:0]    ref_cnt_q;

    // Port decode; switch OFF, high jumper and low jumper step the pair
    wire [2:0]  port_idx   = {jlow_s, jhigh_s, pset_s};          // RQ3
    wire        io_wr      = out_s & ~wr_n_s;
    wire        sel_hit    = addr_s[15:0] == port_addr(port_idx, 1'b0); // RQ1
    wire        ctrl_hit   = addr_s[15:0] == port_addr(port_idx, 1'b1); // RQ1
    wire        wr_trail   = wr_n_s & ~wr_n_prev_q;
    wire        sel_strobe = out_s & sel_hit & wr_trail;          // RQ16
    wire        ctrl_write = io_wr & ctrl_hit & enabled_q;        // RQ17
    wire        code_match = do_s[SEL_CODE_W-1:0] == sel_sw_s;    // RQ23
    wire        win_hit    = enabled_q
                           & (addr_s[HOST_ADDR_W-1:WIN_LSB] == win_sw_s); // RQ24
    wire        rd_stat    = memr_s;
    wire        wr_stat    = ~wo_n_s & ~out_s & ~inp_s;
    wire        word_xfer  = ~xtrq_n_s;
    wire        odd_byte   = addr_s[0];
    wire [3:0]  page_n     = ctrl_q[CTRL_PAGE_LSB +: CTRL_PAGE_W];
    wire [18:0] board_addr = dram_addr(page_n, addr_s[15:0]);    // RQ21
    wire        cpu_rise   = ~cpu_clk_q;

    // Enabled follows each select write; bus reset or a non-matching select write clears it
    always_ff @(posedge ref_clk_i or negedge rst_q) begin
        if (!rst_q) begin
            enabled_q   <= 1'b0;                                  // RQ26
            wr_n_prev_q <= 1'b1;
        end else begin
            wr_n_prev_q <= wr_n_s;
            if (sel_strobe) begin
                enabled_q <= code_match;                          // RQ18
            end
        end
    end

    // Control port; reset leaves the local processor held and the window at page 15
    always_ff @(posedge ref_clk_i or negedge rst_q) begin
        if (!rst_q) begin
            ctrl_q <= CTRL_RESET;                                 // RQ19
        end else if (ctrl_write && wr_trail == 1'b0) begin
            ctrl_q <= do_s;                                       // RQ20
        end
    end

    // Processor clock is half of the board clock, grant re-timed on its
    // falling edge so the host address has settled before the access
    always_ff @(posedge ref_clk_i or negedge rst_q) begin
        if (!rst_q) begin
            cpu_clk_q    <= 1'b0;
            sync_ack_n_q <= 1'b1;
        end else begin
            cpu_clk_q <= ~cpu_clk_q;                              // RQ4
            if (cpu_clk_q) begin
                sync_ack_n_q <= grant_n_s;                        // RQ5
            end
        end
    end

    // Host memory cycle sequencer; the board never asks for mastership
    always_comb begin                                             // RQ22
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (sync_s && win_hit && (rd_stat || wr_stat)) begin
                    state_d = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!sync_ack_n_q) begin
                    state_d = ST_XFER;
                end
            end
            ST_XFER: begin
                if (!dbin_s && wr_n_s) begin
                    state_d = ST_DONE;
                end
            end
            ST_DONE: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    wire xfer_d   = state_d == ST_XFER;
    wire rd_en    = dbin_s & xfer_d & rd_stat & win_hit;          // RQ11
    wire wr_en    = ~wr_n_s & ~grant_n_s & wr_stat & win_hit
                  & (state_q != ST_IDLE);                         // RQ12
    wire cross_rd = rd_en & ~word_xfer & ~odd_byte;               // RQ14
    wire cross_wr = wr_en & ~word_xfer & odd_byte;                // RQ14
    wire uart_sel = lcyc_s & lio_s & ~lio_addr_s[0]
                  & (lio_addr_s[15:UART_SPAN_LSB]
                     == pcs_base_s[15:UART_SPAN_LSB]);            // RQ9
    wire ref_wrap = ref_cnt_q == 10'(REFRESH_CNT - 1);

    // Host side outputs and sequencer state
    always_ff @(posedge ref_clk_i or negedge rst_q) begin
        if (!rst_q) begin
            state_q      <= ST_IDLE;
            host_ready_o <= 1'b1;
            host_di_o    <= 8'h00;
            host_do_o    <= 8'h00;
            host_do_oe_o <= 1'b0;
            host_di_oe_o <= 1'b0;
            sixtn_n_o    <= 1'b1;
        end else begin
            state_q      <= state_d;
            host_ready_o <= state_d != ST_HOLD;                   // RQ25
            host_di_o    <= (word_xfer || odd_byte) ? ldata_s[15:8]
                                                    : ldata_s[7:0];
            host_do_o    <= ldata_s[7:0];                         // RQ13
            host_do_oe_o <= rd_en & word_xfer;                    // RQ13
            host_di_oe_o <= rd_en;
            sixtn_n_o    <= ~((rd_en | wr_en) & word_xfer);       // RQ13
        end
    end

    // Local bus side: address, write data, buffer enables
    always_ff @(posedge ref_clk_i or negedge rst_q) begin
        if (!rst_q) begin
            local_hold_req_o           <= 1'b0;
            local_address_bus_o        <= 19'h00000;
            local_addr_oe_o            <= 1'b0;
            local_data_o               <= 16'h0000;
            local_byte_en_o            <= 2'h0;
            data_out_buffer_enable_n_o <= 1'b1;
            data_in_buffer_enable_n_o  <= 1'b1;
            byte_cross_o               <= 1'b0;
            wait_finished_o            <= 1'b0;
        end else begin
            local_hold_req_o    <= (state_d == ST_HOLD) || xfer_d;
            local_address_bus_o <= board_addr;
            local_addr_oe_o     <= ~grant_n_s
                                 & (state_q != ST_IDLE);          // RQ15
            local_data_o        <= word_xfer ? {di_s, do_s}
                                             : {do_s, do_s};      // RQ14
            local_byte_en_o     <= word_xfer ? 2'h3
                                             : (odd_byte ? 2'h2 : 2'h1);
            data_out_buffer_enable_n_o <= ~(rd_en | wr_en);
            data_in_buffer_enable_n_o  <= ~(rd_en | wr_en);
            byte_cross_o        <= cross_rd | cross_wr;
            wait_finished_o     <= xfer_d;
        end
    end

    // Board status, control bits, local memory and UART selects, refresh
    always_ff @(posedge ref_clk_i or negedge rst_q) begin
        if (!rst_q) begin
            cpu_clock_output_o         <= 1'b0;
            synced_grant_ack_n_o       <= 1'b1;
            board_enabled_n_o          <= 1'b1;
            window_hit_n_o             <= 1'b1;
            local_cpu_reset_n_o        <= 1'b0;
            local_int_set_o            <= 1'b0;
            host_int_enable_o          <= 1'b0;
            row_strobe_n_o             <= 1'b1;
            local_ready_o              <= 1'b1;
            peripheral_select_zero_n_o <= 1'b1;
            uart_reg_o                 <= 4'h0;
            refresh_req_o              <= 1'b0;
            refresh_addr_o             <= 18'h00000;
            ref_cnt_q                  <= 10'h000;
        end else begin
            cpu_clock_output_o   <= cpu_rise;
            synced_grant_ack_n_o <= sync_ack_n_q;
            board_enabled_n_o    <= ~enabled_q;
            window_hit_n_o       <= ~win_hit;                     // RQ24
            local_cpu_reset_n_o  <= ctrl_q[CTRL_CPU_RUN];         // RQ20
            local_int_set_o      <= ctrl_q[CTRL_LINT];
            host_int_enable_o    <= ctrl_q[CTRL_HINT_EN];
            row_strobe_n_o       <= ~(lcyc_s & ~lio_s);           // RQ7
            local_ready_o        <= LOCAL_WAITS == 0;             // RQ8
            peripheral_select_zero_n_o <= ~uart_sel;              // RQ10
            uart_reg_o           <= lio_addr_s[UART_REG_W:1];     // RQ10
            // Refresh only paces the scan; the local DMA does the reads
            ref_cnt_q     <= ref_wrap ? 10'h000 : ref_cnt_q + 10'h001;
            refresh_req_o <= ref_wrap;                            // RQ6
            if (ref_wrap) begin
                refresh_addr_o <= refresh_addr_o + 18'h00001;     // RQ6
            end
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_q);

    chk_select_any: assert property ( // RQ16
        sel_strobe && code_match |=> enabled_q)
        else $error("matching select write did not enable the board");

    chk_enable_hold: assert property ( // RQ18
        !sel_strobe && enabled_q |=> enabled_q)
        else $error("board enable dropped without a select write");

    chk_ctrl_gate: assert property ( // RQ17
        !enabled_q |=> $stable(ctrl_q))
        else $error("control port written while board not enabled");

    chk_window_hit: assert property ( // RQ24
        !enabled_q |=> window_hit_n_o)
        else $error("window hit flagged while board not enabled");

    chk_ready_wait: assert property ( // RQ25
        state_q == ST_HOLD && sync_ack_n_q |=> !host_ready_o)
        else $error("host released before local grant acknowledge");

    chk_grant_sync: assert property ( // RQ5
        !cpu_clk_q |=> $stable(sync_ack_n_q))
        else $error("grant re-timed off the processor clock edge");

    chk_cpu_clock: assert property ( // RQ4
        cpu_clock_output_o |=> !cpu_clock_output_o ##1 cpu_clock_output_o)
        else $error("processor clock is not half the board clock");

    chk_addr_drive: assert property ( // RQ15
        local_addr_oe_o |-> $past(!grant_n_s))
        else $error("local address driven without grant acknowledge");

    chk_row_strobe: assert property ( // RQ7
        lcyc_s && !lio_s |=> !row_strobe_n_o)
        else $error("row strobe missing on a memory cycle");

    chk_refresh_gap: assert property ( // RQ6
        refresh_req_o |=> !refresh_req_o [*8])
        else $error("refresh requests too close together");

    chk_read_buf: assert property ( // RQ11
        !data_out_buffer_enable_n_o && host_di_oe_o |-> $past(dbin_s))
        else $error("read buffers opened without input strobe");

    chk_no_wait: assert property ( // RQ8
        ##1 local_ready_o)
        else $error("wait state inserted on local memory cycle");

endmodule : sbh_host_port

// ===== hdl/sbh_pin_sync.sv
// Three-stage synchroniser for a group of pins with agreement filter
`timescale 1ns/10ps
module sbh_pin_sync #(
    parameter int         W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         ref_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] level_o
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] level_d;

    // Stage one feeds stage two only, metastability stays contained
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_q <= INIT;
            s2_q <= INIT;
            s3_q <= INIT;
        end else begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A bit changes only once stages two and three agree
    assign level_d = (s2_q & s3_q) | (level_o & (s2_q ^ s3_q));

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            level_o <= INIT;
        end else begin
            level_o <= level_d;
        end
    end

endmodule : sbh_pin_sync

// ===== hdl/sbh_pkg.sv
// Constants and types shared by the slave board host port logic
package sbh_pkg;

    // Host I/O port pair: select port at the even address, control at odd
    localparam logic [15:0] SEL_PORT_BASE  = 16'hfc40;
    localparam logic [15:0] CTRL_PORT_BASE = 16'hfc41;
    localparam int          PORT_SET_COUNT = 8;
    localparam logic [15:0] PORT_PAIR_STEP = 16'h0002;

    // Board select code and memory window page
    localparam int          SEL_CODE_W      = 4;
    localparam int          WIN_PAGE_W      = 8;
    localparam int          HOST_ADDR_W     = 24;
    localparam int          WIN_LSB         = 16;

    // Control port fields
    localparam int          CTRL_W          = 8;
    localparam int          CTRL_PAGE_LSB   = 0;
    localparam int          CTRL_PAGE_W     = 4;
    localparam int          CTRL_HINT_EN    = 4;
    localparam int          CTRL_LINT       = 5;
    localparam int          CTRL_CPU_RUN    = 6;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;

    // Board memory: window placed on 32 Kbyte steps in 512 Kbytes
    localparam int          DRAM_ADDR_W     = 19;
    localparam int          PAGE_SHIFT      = 15;
    localparam int          REFRESH_ADDR_W  = 18;

    // Local peripheral chip select for the dual UART
    localparam int          UART_SPAN_LSB   = 5;
    localparam int          UART_REG_W      = 4;

    // Timing at the 40 MHz reference clock
    localparam int          CLK_PERIOD_NS   = 25;
    localparam int          REFRESH_NS      = 16000;
    localparam int          REFRESH_CYCLES  = REFRESH_NS / CLK_PERIOD_NS;
    localparam int          DRAM_ACCESS_NS  = 150;
    localparam int          LOCAL_WAITS     = 0;

    // Host memory cycle sequencer
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HOLD = 2'b01,
        ST_XFER = 2'b11,
        ST_DONE = 2'b10
    } sbh_state_type;

endpackage : sbh_pkg

// ===== tb/sbh_local_cpu_model.sv
// Local processor model: answers the board's hold request on the local bus
`timescale 1ns/10ps
module sbh_local_cpu_model (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        hold_req_i,
    output logic             grant_ack_n_o,
    output logic [15:0]      data_o
);
    logic [2:0] wait_q;
    // Grant after a few cycles, withdraw at once when the request drops
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i || !hold_req_i) begin
            wait_q        <= 3'h0;
            grant_ack_n_o <= 1'b1;
        end else if (wait_q == 3'h4) begin
            grant_ack_n_o <= 1'b0;
        end else begin
            wait_q <= wait_q + 3'h1;
        end
    end
    // Undriven data lines show a changing pattern, never a stale word
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            data_o <= 16'h0f0f;
        end else begin
            data_o <= grant_ack_n_o ? ~data_o : 16'h1234;
        end
    end
endmodule : sbh_local_cpu_model

// ===== tb/tb_sbh_host_port.sv
// Self-checking bench for the slave board host port
`timescale 1ns/10ps
module tb_sbh_host_port;
    import sbh_pkg::*;
    localparam int RCNT = 16;
    logic ref_clk_i, rst_n_i, s_memr_i, s_out_i, s_inp_i, s_wo_n_i, p_dbin_i;
    logic p_wr_n_i, p_sync_i, sxtrq_n_i, port_set_switch_i, port_jumper_low_i;
    logic port_jumper_high_i, local_grant_ack_n_i, local_cycle_i, local_io_i;
    logic host_do_oe_o, host_di_oe_o, sixtn_n_o, host_ready_o, c;
    logic cpu_clock_output_o, local_hold_req_o, synced_grant_ack_n_o;
    logic local_addr_oe_o, byte_cross_o, data_out_buffer_enable_n_o;
    logic data_in_buffer_enable_n_o, wait_finished_o, board_enabled_n_o;
    logic window_hit_n_o, local_cpu_reset_n_o, local_int_set_o;
    logic host_int_enable_o, row_strobe_n_o, local_ready_o, refresh_req_o;
    logic peripheral_select_zero_n_o;
    logic [23:0] host_addr_i;
    logic [7:0]  host_do_i, host_di_i, window_page_switch_i, host_di_o;
    logic [7:0]  host_do_o;
    logic [3:0]  select_code_switch_i, uart_reg_o;
    logic [15:0] local_io_addr_i, local_pcs_base_i, local_data_i, local_data_o;
    logic [18:0] local_address_bus_o;
    logic [1:0]  local_byte_en_o;
    logic [17:0] refresh_addr_o;
    int failures = 0, check_count = 0, cyc = 0, gap;

    sbh_host_port #(.REFRESH_CNT(RCNT)) dut_u (.*);
    sbh_local_cpu_model cpu_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .hold_req_i(local_hold_req_o), .grant_ack_n_o(local_grant_ack_n_i),
        .data_o(local_data_i));

    // Clock and a hang limit well above the run length
    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            test_done();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : tick
    task automatic chk(input string what, input logic [23:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // Strobe held long enough for the pin synchronisers to see both edges
    task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
        host_addr_i = {8'h00, a};
        host_do_i = d;
        s_out_i = 1'b1;
        p_wr_n_i = 1'b0;
        tick(6);
        p_wr_n_i = 1'b1;
        tick(8);
        s_out_i = 1'b0;
        tick(1);
    endtask : io_wr
    // Host memory cycle: rd picks a read (d is then the byte expected on
    // the DI lane), sxtrq_n_i low asks for a word
    task automatic mem_wr(input logic [15:0] a, input logic [7:0] d,
                          input logic hit, rd);
        host_addr_i = {8'h5a, a};
        host_do_i = d;
        {s_wo_n_i, s_memr_i, p_dbin_i, p_wr_n_i} = {rd, rd, rd, rd};
        p_sync_i = 1'b1;
        tick(3);
        p_sync_i = 1'b0;
        for (gap = 0; host_ready_o !== 1'b0 && gap < 12; gap++) tick(1);
        chk("ready", host_ready_o, !hit);
        chk("hit", window_hit_n_o, !hit);
        chk("addr oe", local_addr_oe_o, 1'b0);
        for (gap = 0; hit && host_ready_o !== 1'b1 && gap < 40; gap++) tick(1);
        if (hit) begin
            chk("grant", local_grant_ack_n_i, 1'b0);
            chk("addr", local_address_bus_o, 19'h08000 + a);
            chk("lane", a[0] ? local_data_o[15:8] : local_data_o[7:0], d);
            chk("cross", byte_cross_o, (a[0] ^ rd) & sxtrq_n_i);
            chk("sync ack", synced_grant_ack_n_o, 1'b0);
            chk("word", sixtn_n_o, sxtrq_n_i);
            chk("buf", data_out_buffer_enable_n_o, 1'b0);
            chk("oe", {host_do_oe_o, host_di_oe_o}, {rd & !sxtrq_n_i, rd});
            chk("end wait", wait_finished_o, 1'b1);
            if (rd) chk("rd data", {host_do_o, host_di_o}, {8'h34, d});
        end
        // Strobes and status drop together, the cycle then winds down
        {s_wo_n_i, s_memr_i, p_dbin_i, p_wr_n_i} = 4'b1001;
        tick(8);
        chk("addr off", local_addr_oe_o, 1'b0);
    endtask : mem_wr
    task automatic test_done();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : test_done

    // Main sequence: straps pick port pair 0xfc46, code 9, page 0x5a
    initial begin
        {s_memr_i, s_out_i, s_inp_i, p_dbin_i, p_sync_i} = 5'h00;
        {local_cycle_i, local_io_i, s_wo_n_i, p_wr_n_i, sxtrq_n_i} = 5'h07;
        {host_addr_i, host_do_i, host_di_i, local_io_addr_i} = '0;
        {select_code_switch_i, window_page_switch_i} = 12'h95a;
        {port_jumper_low_i, port_jumper_high_i, port_set_switch_i} = 3'b011;
        local_pcs_base_i = 16'h0100;
        rst_n_i = 1'b0;
        tick(3);
        rst_n_i = 1'b1;
        tick(10);
        chk("cpu reset", local_cpu_reset_n_o, 1'b0);
        io_wr(16'hfc40, 8'h09);
        chk("enable", board_enabled_n_o, 1'b1);
        io_wr(16'hfc47, 8'h4e);
        chk("cpu reset", local_cpu_reset_n_o, 1'b0);
        io_wr(16'hfc46, 8'hf9);
        chk("enable", board_enabled_n_o, 1'b0);
        io_wr(16'hfc47, 8'h7e);
        chk("cpu reset", local_cpu_reset_n_o, 1'b1);
        chk("int bits", {local_int_set_o, host_int_enable_o}, 2'h3);
        mem_wr(16'h0010, 8'h55, 1'b1, 1'b0);
        mem_wr(16'h7ff1, 8'ha6, 1'b1, 1'b0);
        // Reads return the partner's granted word 0x1234
        mem_wr(16'h0010, 8'h34, 1'b1, 1'b1);
        sxtrq_n_i = 1'b0;
        mem_wr(16'h0100, 8'h12, 1'b1, 1'b1);
        sxtrq_n_i = 1'b1;
        io_wr(16'hfc46, 8'h03);
        chk("enable", board_enabled_n_o, 1'b1);
        mem_wr(16'h0020, 8'h11, 1'b0, 1'b0);
        io_wr(16'hfc46, 8'h09);
        io_wr(16'hfc47, 8'h0e);
        chk("cpu reset", local_cpu_reset_n_o, 1'b0);
        local_cycle_i = 1'b1;
        tick(6);
        chk("row", row_strobe_n_o, 1'b0);
        local_io_i = 1'b1;
        local_io_addr_i = 16'h010c;
        tick(6);
        chk("row io", row_strobe_n_o, 1'b1);
        chk("uart sel", peripheral_select_zero_n_o, 1'b0);
        chk("uart reg", uart_reg_o, 4'h6);
        local_io_addr_i = 16'h0120;
        tick(6);
        chk("uart off", peripheral_select_zero_n_o, 1'b1);
        c = cpu_clock_output_o;
        tick(1);
        chk("cpu_clock_output", cpu_clock_output_o, !c);
        for (gap = 0; refresh_req_o !== 1'b1 && gap < 40; gap++) tick(1);
        tick(1);
        for (gap = 1; refresh_req_o !== 1'b1 && gap < 40; gap++) tick(1);
        chk("refresh gap", gap, RCNT);
        rst_n_i = 1'b0;
        tick(2);
        chk("enable", board_enabled_n_o, 1'b1);
        chk("cpu reset", local_cpu_reset_n_o, 1'b0);
        test_done();
    end
endmodule : tb_sbh_host_port
